// File: design/ser_pkg.sv
// package: constants and types for the status event reporting block
package ser_pkg;
	localparam int ACT_W = 16;
	localparam int STD_W = 8;
	localparam logic [ACT_W-1:0] ACT_VALID_MASK = 16'h0019;
	localparam logic [STD_W-1:0] STD_VALID_MASK = 8'hBD;
	localparam logic [ACT_W-1:0] ACT_MASK_RESET = 16'h0000;
	localparam logic [STD_W-1:0] STD_MASK_RESET = 8'h00;
	localparam int SB_STD_BIT = 5;
	localparam int SB_ACT_BIT = 7;
	localparam int ACT_BIT_CORR = 0;
	localparam int ACT_BIT_SWEEP = 3;
	localparam int ACT_BIT_MEAS = 4;
	localparam int STD_BIT_DONE = 0;
	localparam int STD_BIT_READ = 2;
	localparam int STD_BIT_DEVICE = 3;
	localparam int STD_BIT_PARAM = 4;
	localparam int STD_BIT_SYNTAX = 5;
	localparam int STD_BIT_POWER = 7;
	localparam int EQ_DEPTH = 8;
	localparam int EQ_AW = 3;
	localparam int ERR_W = 16;
	// error code parameters; class only, exact numbers belong to firmware
	localparam logic [ERR_W-1:0] ERR_READ_CODE = 16'hFE70;
	localparam logic [ERR_W-1:0] ERR_DEVICE_CODE = 16'hFED4;
	localparam logic [ERR_W-1:0] ERR_PARAM_CODE = 16'hFF38;
	localparam logic [ERR_W-1:0] ERR_SYNTAX_CODE = 16'hFF9C;
	typedef enum logic [2:0] {
		REG_ACT_COND = 3'b000,
		REG_ACT_EVENT = 3'b001,
		REG_ACT_MASK = 3'b010,
		REG_STD_EVENT = 3'b011,
		REG_STD_MASK = 3'b100,
		REG_ERR_QUEUE = 3'b101
	} ser_reg_sel_type;
	typedef struct packed {
		logic ops_complete_flag;
		logic read_fault_flag;
		logic device_fault_flag;
		logic param_fault_flag;
		logic syntax_fault_flag;
	} ser_std_evt_type;
	typedef struct packed {
		logic correction_busy;
		logic sweep_busy;
		logic measure_busy;
	} ser_act_cond_type;
endpackage : ser_pkg

// File: design/ser_err_queue.sv
// error queue memory, registered read data
`timescale 1ns/1ps
module ser_err_queue
	import ser_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// push side
	input wire logic push_i,
	input wire logic [ERR_W-1:0] push_code_i,
	// pop side
	input wire logic pop_i,
	output logic [ERR_W-1:0] pop_code_o,
	output logic empty_o
);
	logic [ERR_W-1:0] mem_reg [EQ_DEPTH];
	logic [EQ_AW-1:0] wr_reg;
	logic [EQ_AW-1:0] rd_reg;
	logic [EQ_AW:0] cnt_reg;
	logic full;
	logic do_push;
	logic do_pop;

	assign full = (cnt_reg == (EQ_AW+1)'(EQ_DEPTH));
	assign empty_o = (cnt_reg == '0);
	// newest error dropped when full, older ones kept
	assign do_push = push_i && !full;
	assign do_pop = pop_i && !empty_o;

	always_ff @(posedge ref_clk_i) begin
		if (do_push) begin
			mem_reg[wr_reg] <= push_code_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			pop_code_o <= '0;
		end else begin
			if (do_push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (do_pop) begin
				rd_reg <= rd_reg + 1'b1;
				pop_code_o <= mem_reg[rd_reg];
			end else if (pop_i) begin
				pop_code_o <= '0;
			end
			cnt_reg <= cnt_reg + {{EQ_AW{1'b0}}, do_push} - {{EQ_AW{1'b0}}, do_pop};
		end
	end
endmodule : ser_err_queue

// File: design/ser_status.sv
// status event reporting core: activity and standard event groups
`timescale 1ns/1ps
module ser_status
	import ser_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// activity conditions, asynchronous to this clock
	input wire ser_act_cond_type act_cond_i,
	// standard event sources, one-cycle pulses on this clock
	input wire ser_std_evt_type std_evt_i,
	input wire logic power_restored_i,
	// host register access
	input wire logic host_rd_i,
	input wire logic host_wr_i,
	input wire ser_reg_sel_type host_sel_i,
	input wire logic [ACT_W-1:0] host_wdata_i,
	output logic [ACT_W-1:0] host_rdata_o,
	// summaries
	output logic [STD_W-1:0] status_byte_o,
	output logic err_queue_empty_o
);
	ser_act_cond_type cond_s1_reg;
	ser_act_cond_type cond_s2_reg;
	logic [ACT_W-1:0] cond_reg;
	logic [ACT_W-1:0] cond_next;
	logic [ACT_W-1:0] act_event_reg;
	logic [ACT_W-1:0] act_event_next;
	logic [ACT_W-1:0] act_mask_reg;
	logic [STD_W-1:0] std_event_reg;
	logic [STD_W-1:0] std_event_next;
	logic [STD_W-1:0] std_mask_reg;
	logic [STD_W-1:0] std_set;
	logic power_seen_reg;
	logic rd_act_event;
	logic rd_std_event;
	logic rd_err;
	logic push;
	logic [ERR_W-1:0] push_code;
	logic [ERR_W-1:0] pop_code;

	function automatic logic any_enabled(input logic [ACT_W-1:0] evt, input logic [ACT_W-1:0] msk);
		any_enabled = |(evt & msk);
	endfunction : any_enabled

	// activity condition inputs pass two flops before use
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cond_s1_reg <= '0;
			cond_s2_reg <= '0;
		end else begin
			cond_s1_reg <= act_cond_i;
			cond_s2_reg <= cond_s1_reg;
		end
	end

	always_comb begin
		cond_next = '0;
		cond_next[ACT_BIT_CORR] = cond_s2_reg.correction_busy;
		cond_next[ACT_BIT_SWEEP] = cond_s2_reg.sweep_busy;
		cond_next[ACT_BIT_MEAS] = cond_s2_reg.measure_busy;
		cond_next = cond_next & ACT_VALID_MASK;
	end

	// condition follows activity only; reads never touch it
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cond_reg <= '0;
		end else begin
			cond_reg <= cond_next;
		end
	end

	assign rd_act_event = host_rd_i && (host_sel_i == REG_ACT_EVENT);
	assign rd_std_event = host_rd_i && (host_sel_i == REG_STD_EVENT);
	assign rd_err = host_rd_i && (host_sel_i == REG_ERR_QUEUE);

	// falling edge of each condition sets its event; set beats the read clear
	always_comb begin
		act_event_next = rd_act_event ? '0 : act_event_reg;
		act_event_next = act_event_next | (cond_reg & ~cond_next);
		act_event_next = act_event_next & ACT_VALID_MASK;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			act_event_reg <= '0;
		end else begin
			act_event_reg <= act_event_next;
		end
	end

	// mask written as signed decimal, stored as raw 16-bit pattern
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			act_mask_reg <= ACT_MASK_RESET;
		end else if (host_wr_i && host_sel_i == REG_ACT_MASK) begin
			act_mask_reg <= host_wdata_i;
		end
	end

	always_comb begin
		std_set = '0;
		std_set[STD_BIT_DONE] = std_evt_i.ops_complete_flag;
		std_set[STD_BIT_READ] = std_evt_i.read_fault_flag;
		std_set[STD_BIT_DEVICE] = std_evt_i.device_fault_flag;
		std_set[STD_BIT_PARAM] = std_evt_i.param_fault_flag;
		std_set[STD_BIT_SYNTAX] = std_evt_i.syntax_fault_flag;
		std_set[STD_BIT_POWER] = power_seen_reg;
	end

	// power-on flag raised once after reset release or on restore pulse
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			power_seen_reg <= 1'b1;
		end else begin
			power_seen_reg <= power_restored_i;
		end
	end

	always_comb begin
		std_event_next = rd_std_event ? '0 : std_event_reg;
		std_event_next = std_event_next | std_set;
		std_event_next = std_event_next & STD_VALID_MASK;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			std_event_reg <= '0;
		end else begin
			std_event_reg <= std_event_next;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			std_mask_reg <= STD_MASK_RESET;
		end else if (host_wr_i && host_sel_i == REG_STD_MASK) begin
			std_mask_reg <= host_wdata_i[STD_W-1:0];
		end
	end

	// one push per cycle; lowest-priority class dropped if two errors coincide
	always_comb begin
		push = 1'b1;
		push_code = '0;
		if (std_set[STD_BIT_SYNTAX]) begin
			push_code = ERR_SYNTAX_CODE;
		end else if (std_set[STD_BIT_PARAM]) begin
			push_code = ERR_PARAM_CODE;
		end else if (std_set[STD_BIT_DEVICE]) begin
			push_code = ERR_DEVICE_CODE;
		end else if (std_set[STD_BIT_READ]) begin
			push_code = ERR_READ_CODE;
		end else begin
			push = 1'b0;
		end
	end

	ser_err_queue u_err_queue (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.push_i(push),
		.push_code_i(push_code),
		.pop_i(rd_err),
		.pop_code_o(pop_code),
		.empty_o(err_queue_empty_o)
	);

	// read data registered one cycle after the read strobe
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			host_rdata_o <= '0;
		end else if (host_rd_i) begin
			case (host_sel_i)
				REG_ACT_COND: host_rdata_o <= cond_reg;
				REG_ACT_EVENT: host_rdata_o <= act_event_reg;
				REG_ACT_MASK: host_rdata_o <= act_mask_reg;
				REG_STD_EVENT: host_rdata_o <= {{(ACT_W-STD_W){1'b0}}, std_event_reg};
				REG_STD_MASK: host_rdata_o <= {{(ACT_W-STD_W){1'b0}}, std_mask_reg};
				default: host_rdata_o <= '0;
			endcase
		end
	end

	// summaries follow the registers, so a cleared event drops its bit; no poll input
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			status_byte_o <= '0;
		end else begin
			status_byte_o <= '0;
			status_byte_o[SB_ACT_BIT] <= any_enabled(act_event_next, act_mask_reg);
			status_byte_o[SB_STD_BIT] <= any_enabled({{(ACT_W-STD_W){1'b0}}, std_event_next},
				{{(ACT_W-STD_W){1'b0}}, std_mask_reg});
		end
	end

	// queue contents stay inside; the bus reads zero at that select
	logic [ERR_W-1:0] unused_pop;
	assign unused_pop = pop_code;
endmodule : ser_status

// File: tb/ser_status_sva.sv
// checker: port-level properties of the status block
`timescale 1ns/1ps
module ser_status_sva
	import ser_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// inputs
	input wire ser_act_cond_type act_cond_i,
	input wire ser_std_evt_type std_evt_i,
	input wire logic power_restored_i,
	input wire logic host_rd_i,
	input wire logic host_wr_i,
	input wire ser_reg_sel_type host_sel_i,
	input wire logic [ACT_W-1:0] host_wdata_i,
	// outputs
	input wire logic [ACT_W-1:0] host_rdata_o,
	input wire logic [STD_W-1:0] status_byte_o
);
	logic [ACT_W-1:0] am_reg;
	logic [STD_W-1:0] sm_reg;
	logic std_q;
	logic act_q;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	assign std_q = host_rd_i && host_sel_i == REG_STD_EVENT && std_evt_i == '0 && !power_restored_i;
	assign act_q = host_rd_i && host_sel_i == REG_ACT_EVENT;
	// shadow masks, so summaries tie to what the host wrote
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			am_reg <= 16'h0000;
			sm_reg <= 8'h00;
		end else if (host_wr_i && host_sel_i == REG_ACT_MASK) begin
			am_reg <= host_wdata_i;
		end else if (host_wr_i && host_sel_i == REG_STD_MASK) begin
			sm_reg <= host_wdata_i[7:0];
		end
	end
	a_cond_valid_bits: assert property (host_rd_i && host_sel_i == REG_ACT_COND
		|=> (host_rdata_o & ~ACT_VALID_MASK) == 16'h0000) else $error("cond bit");
	a_act_valid_bits: assert property (act_q
		|=> (host_rdata_o & ~ACT_VALID_MASK) == 16'h0000) else $error("act bit");
	a_std_valid_bits: assert property (host_rd_i && host_sel_i == REG_STD_EVENT
		|=> (host_rdata_o & ~{8'h00, STD_VALID_MASK}) == 16'h0000) else $error("std bit");
	a_std_read_clear: assert property ($past(rstn_i) && !$past(power_restored_i) && std_q
		##1 (std_evt_i == '0 && !power_restored_i) ##1 std_q
		|=> host_rdata_o == 16'h0000) else $error("std not cleared");
	a_std_sum_clear: assert property ($past(rstn_i) && !$past(power_restored_i) && std_q
		|=> !status_byte_o[SB_STD_BIT]) else $error("std sum stuck");
	a_act_sum_clear: assert property ((act_cond_i == '0)[*5] ##0 act_q
		|=> !status_byte_o[SB_ACT_BIT]) else $error("act sum stuck");
	a_act_sum_mask: assert property (status_byte_o[SB_ACT_BIT]
		|-> ((am_reg | $past(am_reg)) & ACT_VALID_MASK) != 16'h0000) else $error("act sum");
	a_std_sum_mask: assert property (status_byte_o[SB_STD_BIT]
		|-> ((sm_reg | $past(sm_reg)) & STD_VALID_MASK) != 8'h00) else $error("std sum");
endmodule : ser_status_sva

bind ser_status ser_status_sva chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
	.act_cond_i(act_cond_i), .std_evt_i(std_evt_i), .power_restored_i(power_restored_i),
	.host_rd_i(host_rd_i), .host_wr_i(host_wr_i), .host_sel_i(host_sel_i),
	.host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o), .status_byte_o(status_byte_o));

// File: tb/ser_host.sv
// host model: register reads and writes into the status block
`timescale 1ns/1ps
module ser_host
	import ser_pkg::*;
(
	// clock
	input wire logic ref_clk_i,
	// register access
	output logic host_rd_o,
	output logic host_wr_o,
	output ser_reg_sel_type host_sel_o,
	output logic [ACT_W-1:0] host_wdata_o,
	input wire logic [ACT_W-1:0] host_rdata_i
);
	initial begin
		host_rd_o = 1'b0;
		host_wr_o = 1'b0;
		host_sel_o = REG_ACT_COND;
		host_wdata_o = 16'h0000;
	end
	task rd(input ser_reg_sel_type sel, output logic [ACT_W-1:0] data);
		@(posedge ref_clk_i);
		host_rd_o <= 1'b1;
		host_sel_o <= sel;
		@(posedge ref_clk_i);
		host_rd_o <= 1'b0;
		#1 data = host_rdata_i;
	endtask : rd
	// data inverted after the strobe, so a stale word never looks valid
	task wr(input ser_reg_sel_type sel, input logic [ACT_W-1:0] data);
		@(posedge ref_clk_i);
		host_wr_o <= 1'b1;
		host_sel_o <= sel;
		host_wdata_o <= data;
		@(posedge ref_clk_i);
		host_wr_o <= 1'b0;
		host_wdata_o <= ~data;
	endtask : wr
	task wr_masks(input int act, input int std);
		wr(REG_ACT_MASK, act[15:0]);
		wr(REG_STD_MASK, {8'h00, std[7:0]});
	endtask : wr_masks
endmodule : ser_host

// File: tb/tb_status_event_reporting.sv
// testbench: register-level tests of the status block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_status_event_reporting
	import ser_pkg::*;
;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	ser_act_cond_type act_cond_i = '0;
	ser_std_evt_type std_evt_i = '0;
	logic power_restored_i = 1'b0;
	logic host_rd_i;
	logic host_wr_i;
	ser_reg_sel_type host_sel_i;
	logic [ACT_W-1:0] host_wdata_i;
	logic [ACT_W-1:0] host_rdata_o;
	logic [ACT_W-1:0] d;
	logic [STD_W-1:0] status_byte_o;
	logic err_queue_empty_o;
	int err_total = 0;
	int total_checks = 0;
	int cycles = 0;
	int std_bit[5] = '{5, 4, 3, 2, 0};
	logic [ACT_W-1:0] act_bit[3] = '{16'h0010, 16'h0008, 16'h0001};
	ser_status uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .act_cond_i(act_cond_i),
		.std_evt_i(std_evt_i), .power_restored_i(power_restored_i), .host_rd_i(host_rd_i),
		.host_wr_i(host_wr_i), .host_sel_i(host_sel_i), .host_wdata_i(host_wdata_i),
		.host_rdata_o(host_rdata_o), .status_byte_o(status_byte_o),
		.err_queue_empty_o(err_queue_empty_o));
	ser_host host (.ref_clk_i(ref_clk_i), .host_rd_o(host_rd_i), .host_wr_o(host_wr_i),
		.host_sel_o(host_sel_i), .host_wdata_o(host_wdata_i), .host_rdata_i(host_rdata_o));
	always #2 ref_clk_i = ~ref_clk_i;
	task give_verdict;
		if (err_total == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	task tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : tick
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			give_verdict();
		end
	end
	initial begin
		repeat (10) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		tick(2);
		host.rd(REG_ACT_MASK, d);
		`CHK(d, 16'h0000)
		host.rd(REG_STD_MASK, d);
		`CHK(d, 16'h0000)
		host.rd(REG_STD_EVENT, d);
		`CHK(d, 16'h0080)
		host.rd(REG_STD_EVENT, d);
		`CHK(d, 16'h0000)
		host.wr_masks(-32768, 255);
		host.rd(REG_STD_MASK, d);
		`CHK(d, 16'h00FF)
		host.rd(REG_ACT_MASK, d);
		`CHK(d, 16'h8000)
		for (int i = 0; i < 5; i++) begin
			@(posedge ref_clk_i);
			std_evt_i <= 5'b00001 << i;
			@(posedge ref_clk_i);
			std_evt_i <= '0;
			tick(1);
			`CHK(status_byte_o, 8'h20)
			host.rd(REG_STD_EVENT, d);
			`CHK(d, 16'h0001 << std_bit[i])
			`CHK(status_byte_o[5], 1'b0)
		end
		`CHK(err_queue_empty_o, 1'b0)
		// four error pulses above; the bus shows zero while the queue drains
		for (int i = 0; i < 4; i++) begin
			host.rd(REG_ERR_QUEUE, d);
			`CHK(d, 16'h0000)
		end
		`CHK(err_queue_empty_o, 1'b1)
		@(posedge ref_clk_i);
		power_restored_i <= 1'b1;
		@(posedge ref_clk_i);
		power_restored_i <= 1'b0;
		host.rd(REG_STD_EVENT, d);
		`CHK(d, 16'h0080)
		// only unused bit 15 enabled: a real event must not reach the summary
		@(posedge ref_clk_i);
		act_cond_i <= 3'b001;
		tick(6);
		@(posedge ref_clk_i);
		act_cond_i <= '0;
		tick(6);
		`CHK(status_byte_o[7], 1'b0)
		host.wr_masks(-1, 0);
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk_i);
			act_cond_i <= 3'b001 << i;
			tick(6);
			host.rd(REG_ACT_COND, d);
			`CHK(d, act_bit[i])
			host.rd(REG_ACT_COND, d);
			`CHK(d, act_bit[i])
			host.rd(REG_ACT_EVENT, d);
			`CHK(d, (i == 0) ? 16'h0010 : 16'h0000)
			@(posedge ref_clk_i);
			act_cond_i <= '0;
			tick(6);
			`CHK(status_byte_o, 8'h80)
			host.rd(REG_ACT_EVENT, d);
			`CHK(d, act_bit[i])
			`CHK(status_byte_o[7], 1'b0)
		end
		host.wr(ser_reg_sel_type'(3'h7), 16'hFFFF);
		host.rd(ser_reg_sel_type'(3'h7), d);
		`CHK(d, 16'h0000)
		host.rd(REG_STD_MASK, d);
		`CHK(d, 16'h0000)
		give_verdict();
	end
endmodule : tb_status_event_reporting
